// file: logic/scr_spare_control.sv
`timescale 1ns/100ps
module scr_spare_control (
   // clock and power-on reset
   input wire logic sys_clk,
   input wire logic resetn,
   // register access port
   input wire scr_pkg::scr_reg_req_s regReq,
   output logic [7:0] regRdData,
   output logic regRdValid,
   // device state and request pins
   input wire logic deviceOnState,
   input wire logic power_request_pin,
   input wire logic clock_request_pin,
   // raw 32k clock from the rc oscillator
   input wire logic clk32kRaw,
   // 32k clock output pin
   output logic clk32kPinOut,
   output logic clk32kPinOe,
   // fast oscillator enable
   output logic fastOscRun,
   // converter control, clock drive select and oscillator gate enable
   output logic buck4_immediate_step,
   output logic buck4_delay_select,
   output logic clk_out_drive_sel,
   output logic fast_osc_gate_en
);

   // address match, used by both write and read paths
   function automatic logic hitSpare(input logic [7:0] addr);
      hitSpare = (addr == scr_pkg::SPARE_CONTROL_OFFSET);
   endfunction

   // full register image with unused nibble forced to zero
   function automatic logic [7:0] spareImage(input scr_pkg::scr_spare_s f);
      spareImage = {scr_pkg::UNUSED_FIELD_VALUE, f};
   endfunction

   scr_pkg::scr_spare_s spare_q;
   scr_pkg::scr_spare_s spare_d;
   logic [7:0] rdData_q;
   logic [7:0] rdData_d;
   logic rdValid_q;
   logic rdValid_d;

   // register next state: write stores only the four used bits
   always_comb begin
      spare_d = spare_q;
      if (regReq.wrEn && hitSpare(regReq.addr)) begin
         spare_d = scr_pkg::scr_spare_s'(regReq.wrData[scr_pkg::USED_FIELD_WIDTH-1:0]);
      end
   end

   // read path; unmapped offsets answer a fixed value rather than stale data
   always_comb begin
      rdValid_d = regReq.rdEn;
      rdData_d = rdData_q;
      if (regReq.rdEn) begin
         if (hitSpare(regReq.addr)) begin
            rdData_d = spareImage(spare_q);
         end else begin
            rdData_d = scr_pkg::UNMAPPED_READ_VALUE;
         end
      end
   end

   // register and read flops
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         spare_q <= scr_pkg::scr_spare_s'(scr_pkg::SPARE_CONTROL_RESET[scr_pkg::USED_FIELD_WIDTH-1:0]);
         rdData_q <= scr_pkg::SPARE_CONTROL_RESET;
         rdValid_q <= 1'b0;
      end else begin
         spare_q <= spare_d;
         rdData_q <= rdData_d;
         rdValid_q <= rdValid_d;
      end
   end

   // read strobe answers exactly one cycle later
   rd_valid_pulse_a: assert property (
      @(posedge sys_clk) disable iff (!resetn)
      resetn |=> regRdValid == $past(regReq.rdEn))
      else $error("read valid pulse wrong");

   // read data stands until the next read
   rd_data_hold_a: assert property (
      @(posedge sys_clk) disable iff (!resetn)
      resetn && !regReq.rdEn |=> $stable(regRdData))
      else $error("read data changed without a read");

   // offsets other than spare_control read a fixed zero
   unmapped_read_a: assert property (
      @(posedge sys_clk) disable iff (!resetn)
      resetn && regReq.rdEn && !hitSpare(regReq.addr)
      |=> regRdValid && (regRdData == scr_pkg::UNMAPPED_READ_VALUE))
      else $error("unmapped read not zero");

   // a read in the cycle of a write returns the old contents
   same_cycle_rdwr_a: assert property (
      @(posedge sys_clk) disable iff (!resetn)
      resetn && regReq.rdEn && regReq.wrEn && hitSpare(regReq.addr) |=> regRdData == {4'h0, $past(spare_q)})
      else $error("read during write not old value");

   // drive select and gating bits follow written data
   gate_sel_store_a: assert property (
      @(posedge sys_clk) disable iff (!resetn)
      resetn && regReq.wrEn && hitSpare(regReq.addr)
      |=> fast_osc_gate_en == $past(regReq.wrData[3]) && clk_out_drive_sel == $past(regReq.wrData[0]))
      else $error("gate or drive select bit not stored");

   logic clkPinOut_d;
   logic clkPinOe_d;
   logic clkPinOut_q;
   logic clkPinOe_q;

   // 32k output driver: open-drain only ever pulls low, high comes from the pull-up
   always_comb begin
      if (spare_q.clkOutDriveSel == scr_pkg::DRIVE_OPEN_DRAIN) begin
         clkPinOut_d = 1'b0;
         clkPinOe_d = !clk32kRaw;
      end else begin
         clkPinOut_d = clk32kRaw;
         clkPinOe_d = 1'b1;
      end
   end

   logic oscRun_d;
   logic oscRun_q;

   // fast oscillator gating; always off outside the on state
   always_comb begin
      if (!deviceOnState) begin
         oscRun_d = 1'b0;
      end else if (!spare_q.fastOscGateEn) begin
         oscRun_d = 1'b1;
      end else begin
         oscRun_d = power_request_pin || clock_request_pin;
      end
   end

   // oscillator is held off outside the on state
   osc_off_state_a: assert property (
      @(posedge sys_clk) disable iff (!resetn)
      resetn && !deviceOnState |=> !fastOscRun)
      else $error("fast oscillator running outside on state");

   // pin and oscillator flops, one cycle behind their causes
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         clkPinOut_q <= 1'b0;
         clkPinOe_q <= 1'b0;
         oscRun_q <= 1'b0;
      end else begin
         clkPinOut_q <= clkPinOut_d;
         clkPinOe_q <= clkPinOe_d;
         oscRun_q <= oscRun_d;
      end
   end

   // outputs straight from flops
   assign regRdData = rdData_q;
   assign regRdValid = rdValid_q;
   assign clk32kPinOut = clkPinOut_q;
   assign clk32kPinOe = clkPinOe_q;
   assign fastOscRun = oscRun_q;
   assign buck4_immediate_step = spare_q.buck4ImmediateStep;
   assign buck4_delay_select = spare_q.buck4DelaySelect;
   assign clk_out_drive_sel = spare_q.clkOutDriveSel;
   assign fast_osc_gate_en = spare_q.fastOscGateEn;

   // upper nibble of a spare_control read is zero
   upper_zero_a: assert property (
      @(posedge sys_clk) disable iff (!resetn)
      regReq.rdEn && hitSpare(regReq.addr) |=> regRdValid && (regRdData[7:4] == 4'h0))
      else $error("spare_control upper bits read nonzero");

   // a write is read back on the next read
   write_readback_a: assert property (
      @(posedge sys_clk) disable iff (!resetn)
      regReq.wrEn && hitSpare(regReq.addr) ##1 regReq.rdEn && hitSpare(regReq.addr) && !regReq.wrEn
      |=> regRdData == {4'h0, $past(regReq.wrData[3:0], 2)})
      else $error("spare_control readback mismatch");

   // push-pull drives every cycle and follows the raw clock
   // sampled resetn skips the release edge, which the flops still spend in reset
   push_pull_a: assert property (
      @(posedge sys_clk) disable iff (!resetn)
      resetn && !clk_out_drive_sel && !(regReq.wrEn && hitSpare(regReq.addr))
      |=> clk32kPinOe && (clk32kPinOut == $past(clk32kRaw)))
      else $error("push-pull clock output wrong");

   // open-drain never drives high, pulls low exactly when the clock is low
   open_drain_a: assert property (
      @(posedge sys_clk) disable iff (!resetn)
      resetn && clk_out_drive_sel && !(regReq.wrEn && hitSpare(regReq.addr))
      |=> !clk32kPinOut && (clk32kPinOe == !$past(clk32kRaw)))
      else $error("open-drain clock output wrong");

   // ungated oscillator stays on through the on state
   osc_continuous_a: assert property (
      @(posedge sys_clk) disable iff (!resetn)
      resetn && deviceOnState && !fast_osc_gate_en |=> fastOscRun)
      else $error("fast oscillator stopped while ungated");

   // gated oscillator stops only with both pins low
   osc_gated_off_a: assert property (
      @(posedge sys_clk) disable iff (!resetn)
      resetn && deviceOnState && fast_osc_gate_en |=> fastOscRun == $past(power_request_pin || clock_request_pin))
      else $error("gated fast oscillator state wrong");

   // converter bits follow written data
   buck4_bits_a: assert property (
      @(posedge sys_clk) disable iff (!resetn)
      regReq.wrEn && hitSpare(regReq.addr)
      |=> buck4_immediate_step == $past(regReq.wrData[1]) && buck4_delay_select == $past(regReq.wrData[2]))
      else $error("buck4 control bits not stored");

   // register holds when not written
   reg_hold_a: assert property (
      @(posedge sys_clk) disable iff (!resetn)
      !(regReq.wrEn && hitSpare(regReq.addr)) |=> $stable(spare_q))
      else $error("spare_control changed without a write");

endmodule // scr_spare_control

// file: logic/scr_pkg.sv
package scr_pkg;

   // register map
   localparam logic [7:0] SPARE_CONTROL_OFFSET = 8'h63;
   localparam logic [7:0] SPARE_CONTROL_RESET = 8'h00;
   localparam logic [7:0] UNMAPPED_READ_VALUE = 8'h00;

   // field positions inside spare_control
   localparam int CLK_OUT_DRIVE_SEL_POS = 0;
   localparam int BUCK4_IMMEDIATE_STEP_POS = 1;
   localparam int BUCK4_DELAY_SELECT_POS = 2;
   localparam int FAST_OSC_GATE_EN_POS = 3;
   localparam int USED_FIELD_WIDTH = 4;

   // upper nibble has no function and reads back as zero
   localparam logic [3:0] UNUSED_FIELD_VALUE = 4'h0;

   // clock output drive modes, as encoded in clk_out_drive_sel
   localparam logic DRIVE_PUSH_PULL = 1'b0;
   localparam logic DRIVE_OPEN_DRAIN = 1'b1;

   // stored fields, msb first matches bit 3 down to bit 0
   typedef struct packed {
      logic fastOscGateEn;
      logic buck4DelaySelect;
      logic buck4ImmediateStep;
      logic clkOutDriveSel;
   } scr_spare_s;

   // register port request
   typedef struct packed {
      logic wrEn;
      logic rdEn;
      logic [7:0] addr;
      logic [7:0] wrData;
   } scr_reg_req_s;

endpackage

// file: dv/test_spare_control_register.sv
`timescale 1ns/100ps
module test_spare_control_register;
   // clock, reset and request inputs
   logic sys_clk = 1'b0;
   logic resetn = 1'b0;
   scr_pkg::scr_reg_req_s regReq = '0;
   logic deviceOnState = 1'b0;
   logic power_request_pin = 1'b0;
   logic clock_request_pin = 1'b0;
   logic clk32kRaw = 1'b0;
   // observed outputs
   logic [7:0] regRdData;
   logic regRdValid, clk32kPinOut, clk32kPinOe, fastOscRun;
   logic buck4_immediate_step, buck4_delay_select, clk_out_drive_sel, fast_osc_gate_en;
   int numErrors = 0;
   int checksDone = 0;
   logic [7:0] exp;

   // 40 mhz clock
   always #12.5 sys_clk = ~sys_clk;

   scr_spare_control dut (.sys_clk(sys_clk), .resetn(resetn), .regReq(regReq), .regRdData(regRdData),
      .regRdValid(regRdValid), .deviceOnState(deviceOnState), .power_request_pin(power_request_pin),
      .clock_request_pin(clock_request_pin), .clk32kRaw(clk32kRaw), .clk32kPinOut(clk32kPinOut),
      .clk32kPinOe(clk32kPinOe), .fastOscRun(fastOscRun), .buck4_immediate_step(buck4_immediate_step),
      .buck4_delay_select(buck4_delay_select), .clk_out_drive_sel(clk_out_drive_sel),
      .fast_osc_gate_en(fast_osc_gate_en));

   task automatic chk(input string what, input logic [7:0] want, input logic [7:0] got);
      checksDone++;
      if (got !== want) begin
         numErrors++;
         $display("mismatch %s expected %h seen %h", what, want, got);
      end
   endtask

   // one-cycle strobe, sampled just after the answer edge
   task automatic access(input logic wr, input logic [7:0] addr, input logic [7:0] data);
      @(posedge sys_clk) regReq <= '{wrEn: wr, rdEn: !wr, addr: addr, wrData: data};
      @(posedge sys_clk) regReq <= '0;
      #1;
   endtask

   task automatic readReg(input logic [7:0] addr, input logic [7:0] want);
      access(1'b0, addr, 8'h00);
      chk("rdValid", 8'h01, {7'h00, regRdValid});
      chk("rdData", want, regRdData);
   endtask

   // registered outputs need one edge after an input change; settle waits two
   task automatic settle();
      repeat (2) @(posedge sys_clk);
      #1;
   endtask

   function automatic logic [7:0] fields();
      return {4'h0, fast_osc_gate_en, buck4_delay_select, buck4_immediate_step, clk_out_drive_sel};
   endfunction

   task automatic resetValues();
      readReg(8'h63, 8'h00);
      chk("fields", 8'h00, fields());
   endtask

   task automatic fieldWrite();
      access(1'b1, 8'h63, 8'hff);
      readReg(8'h63, 8'h0f);
      settle();
      chk("fields", 8'h0f, fields());
      access(1'b1, 8'h63, 8'ha5);
      readReg(8'h63, 8'h05);
      settle();
      chk("fields", 8'h05, fields());
   endtask

   // stray writes elsewhere must not touch the register
   task automatic unmappedAccess();
      access(1'b1, 8'h64, 8'h0a);
      access(1'b1, 8'h62, 8'h0a);
      readReg(8'h62, 8'h00);
      readReg(8'h63, 8'h05);
   endtask

   task automatic oscGate();
      for (int g = 0; g < 2; g++) begin
         access(1'b1, 8'h63, g[0] ? 8'h08 : 8'h00);
         for (int i = 0; i < 8; i++) begin
            @(posedge sys_clk) {deviceOnState, power_request_pin, clock_request_pin} <= i[2:0];
            settle();
            exp = {7'h00, i[2] & (!g[0] | i[1] | i[0])};
            chk("fastOscRun", exp, {7'h00, fastOscRun});
         end
      end
   endtask

   task automatic clkPin();
      for (int i = 0; i < 4; i++) begin
         access(1'b1, 8'h63, {7'h00, i[1]});
         @(posedge sys_clk) clk32kRaw <= i[0];
         settle();
         exp = i[1] ? {6'h00, 1'b0, !i[0]} : {6'h00, i[0], 1'b1};
         chk("pinOutOe", exp, {6'h00, clk32kPinOut, clk32kPinOe});
      end
   endtask

   // write, read, then write with read in one cycle, no idle gaps
   task automatic backToBack();
      @(posedge sys_clk) regReq <= '{wrEn: 1'b1, rdEn: 1'b0, addr: 8'h63, wrData: 8'h0c};
      @(posedge sys_clk) regReq <= '{wrEn: 1'b0, rdEn: 1'b1, addr: 8'h63, wrData: 8'h00};
      @(posedge sys_clk) regReq <= '{wrEn: 1'b1, rdEn: 1'b1, addr: 8'h63, wrData: 8'h03};
      #1;
      chk("rdData", 8'h0c, regRdData);
      @(posedge sys_clk) regReq <= '0;
      #1;
      chk("rdData", 8'h0c, regRdData);
      chk("fields", 8'h03, fields());
      readReg(8'h63, 8'h03);
   endtask

   // power-on reset in mid-run clears a nonzero register
   task automatic midRunReset();
      access(1'b1, 8'h63, 8'h0f);
      @(posedge sys_clk) resetn <= 1'b0;
      #1;
      chk("fields", 8'h00, fields());
      chk("pinOutOe", 8'h00, {6'h00, clk32kPinOut, clk32kPinOe});
      chk("fastOscRun", 8'h00, {7'h00, fastOscRun});
      repeat (3) @(posedge sys_clk);
      resetn <= 1'b1;
      resetValues();
   endtask

   task automatic giveVerdict();
      if (numErrors == 0 && checksDone > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   // main sequence
   initial begin
      repeat (12) @(posedge sys_clk);
      resetn <= 1'b1;
      resetValues();
      fieldWrite();
      unmappedAccess();
      backToBack();
      oscGate();
      clkPin();
      midRunReset();
      giveVerdict();
   end
endmodule // test_spare_control_register
